// ==== core/pkt_pkg.sv ====
// constants, state types and byte helpers of the radio packet handler
// assumes one 50 MHz clock domain and byte-wide links to host and modem
package pkt_pkg;
    localparam int FIFO_DEPTH = 16;
    localparam int BYTE_W = 8;
    localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
    localparam logic [2:0] SYNC_Q32_A = 3'h3;
    localparam logic [2:0] SYNC_Q32_B = 3'h7;
    localparam logic [2:0] SYNC_BYTES_16 = 3'h2;
    localparam logic [2:0] SYNC_BYTES_32 = 3'h4;
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [1:0] LEN_VAR = 2'h1;
    localparam logic [1:0] LEN_INF = 2'h2;
    localparam logic [1:0] ADR_OFF = 2'h0;
    localparam logic [1:0] ADR_ZERO = 2'h2;
    localparam logic [1:0] ADR_BOTH = 2'h3;
    localparam logic [7:0] ADR_BCAST_LO = 8'h00;
    localparam logic [7:0] ADR_BCAST_HI = 8'hff;
    localparam logic [7:0] INF_ADR_MARK = 8'hff;
    localparam logic [8:0] PN9_INIT = 9'h1ff;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [7:0] PRE_CNT_MAX = 8'hff;

    typedef enum logic [2:0] {
        T_IDLE = 3'b000, T_PRE = 3'b001, T_SYNC = 3'b010,
        T_DATA = 3'b011, T_CRC = 3'b100, T_UNDER = 3'b101
    } tx_state_e;

    typedef enum logic [2:0] {
        R_HUNT = 3'b000, R_BODY = 3'b001, R_CRC = 3'b010,
        R_STAT1 = 3'b011, R_STAT2 = 3'b100
    } rx_state_e;

    // eight steps of x^9 + x^5 + 1, one byte of whitening per call
    function automatic logic [8:0] pn9_adv(input logic [8:0] s);
        logic [8:0] r;
        r = s;
        for (int i = 0; i < 8; i++) begin
            r = {r[0] ^ r[5], r[8:1]};
        end
        return r;
    endfunction : pn9_adv

    // msb-first checksum; residue over data plus checksum is zero
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_byte
endpackage : pkt_pkg

// ==== core/byte_stream_if.sv ====
// valid/ready byte stream between the packet handler and its fifo
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ==== core/stream_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock; clock enable low freezes it
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_s;
    fifo_s q;
    fifo_s d;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // ready is honest: full or frozen refuses
    assign in_s.ready = ce_i && (q.cnt != (AW+1)'(DEPTH));
    assign out_s.valid = (q.cnt != '0);
    assign out_s.data = mem[q.rp];
    assign push = in_s.valid && in_s.ready;
    assign pop = ce_i && out_s.valid && out_s.ready;

    // pointer and fill update
    always_comb begin
        d = q;
        if (push) begin
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // storage has no reset, only written words are read
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[q.wp] <= in_s.data;
        end
    end
endmodule : stream_fifo
`default_nettype wire

// ==== core/radio_packet_handler.sv ====
// packet framer and deframer between host byte streams and the modem
// assumes modem byte strobes on clk_i, at least two cycles apart on receive
`timescale 1ns/1ps
`default_nettype none
module radio_packet_handler
    import pkt_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_start_i,
    input wire logic tx_stop_i,
    output logic [7:0] tx_sym_o,
    output logic tx_sym_valid_o,
    input wire logic tx_sym_ready_i,
    output logic tx_done_o,
    output logic tx_underflow_o,
    input wire logic rx_en_i,
    input wire logic rx_sync_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_byte_valid_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_done_o,
    output logic rx_discard_o,
    output logic [1:0] exit_state_o,
    input wire logic [7:0] preamble_count_i,
    input wire logic [7:0] sync_high_byte_i,
    input wire logic [7:0] sync_low_byte_i,
    input wire logic [2:0] sync_qualifier_mode_i,
    input wire logic whitening_enable_i,
    input wire logic crc_enable_i,
    input wire logic append_status_i,
    input wire logic [1:0] length_mode_select_i,
    input wire logic [7:0] packet_length_limit_i,
    input wire logic [1:0] address_check_mode_i,
    input wire logic [7:0] node_address_i,
    input wire logic [1:0] tx_exit_state_i,
    input wire logic [1:0] rx_exit_state_i,
    input wire logic [7:0] signal_strength_value_i,
    input wire logic [6:0] link_quality_value_i
);
    typedef struct packed {
        tx_state_e tst;
        logic [7:0] pre_cnt;
        logic [2:0] idx;
        logic [7:0] cnt;
        logic [7:0] len;
        logic [8:0] tpn;
        logic [15:0] tcrc;
        logic [7:0] tbyte;
        logic tvalid;
        logic tdone;
        rx_state_e rst;
        logic len_due;
        logic adr_due;
        logic ridx;
        logic [7:0] rcnt;
        logic [7:0] rlen;
        logic [8:0] rpn;
        logic [15:0] rcrc;
        logic [7:0] rdata;
        logic rvalid;
        logic rpend;
        logic [7:0] raddr;
        logic rdiscard;
        logic rdone;
        logic [1:0] nxt;
    } ph_s;

    ph_s q;
    ph_s d;
    byte_stream_if #(.W(BYTE_W)) host_if ();
    byte_stream_if #(.W(BYTE_W)) pull_if ();

    logic hs;
    logic sync32;
    logic [2:0] sync_len;
    logic [7:0] twmask;
    logic [7:0] rwmask;
    logic [7:0] rx_in;
    logic tx_last;
    logic adr_ok;
    logic crc_ok;
    logic [7:0] rnext;
    logic rx_end;

    // host side fills the fifo; its ready throttles the host
    assign host_if.data = tx_data_i;
    assign host_if.valid = tx_valid_i;
    assign tx_ready_o = host_if.ready;

    stream_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) tx_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .in_s(host_if.snk),
        .out_s(pull_if.src)
    );

    // shared decode of configuration
    assign hs = q.tvalid && tx_sym_ready_i;
    assign sync32 = (sync_qualifier_mode_i == SYNC_Q32_A) || (sync_qualifier_mode_i == SYNC_Q32_B);
    assign sync_len = sync32 ? SYNC_BYTES_32 : SYNC_BYTES_16;
    assign twmask = whitening_enable_i ? q.tpn[7:0] : 8'h00;
    assign rwmask = whitening_enable_i ? q.rpn[7:0] : 8'h00;
    assign rx_in = rx_byte_i ^ rwmask;
    assign crc_ok = !crc_enable_i || (q.rcrc == 16'h0000);
    assign rnext = q.rcnt + 8'h01; // wraps 255 to 0
    // end test uses the live limit so the host may retarget mid-packet
    assign tx_last = (length_mode_select_i == LEN_INF) ? tx_stop_i :
                     (length_mode_select_i == LEN_VAR) ? (q.cnt == q.len) :
                     (q.cnt == packet_length_limit_i);
    assign rx_end = (length_mode_select_i == LEN_FIXED) ? (rnext == packet_length_limit_i) :
                    (length_mode_select_i == LEN_VAR) ? (rnext == q.rlen) : 1'b0;
    // node address, plus broadcast values by mode
    assign adr_ok = (rx_in == node_address_i) ||
                    ((address_check_mode_i == ADR_ZERO) && (rx_in == ADR_BCAST_LO)) ||
                    ((address_check_mode_i == ADR_BOTH) && ((rx_in == ADR_BCAST_LO) ||
                                                            (rx_in == ADR_BCAST_HI)));

    // next-state logic for both directions
    always_comb begin
        d = q;
        d.tdone = 1'b0;
        d.rvalid = 1'b0;
        d.rdiscard = 1'b0;
        d.rdone = 1'b0;
        pull_if.ready = 1'b0;
        // transmit framer
        case (q.tst)
            T_IDLE: begin
                if (tx_start_i) begin
                    d.tst = T_PRE; // preamble is never skipped
                    d.tbyte = PREAMBLE_BYTE;
                    d.tvalid = 1'b1;
                    d.pre_cnt = 8'h01;
                end
            end
            T_PRE: begin
                if (hs) begin
                    if ((q.pre_cnt >= preamble_count_i) && pull_if.valid) begin
                        d.tst = T_SYNC;
                        d.tbyte = sync_high_byte_i;
                        d.idx = 3'h1;
                        d.tpn = PN9_INIT;
                    end else begin
                        d.tbyte = PREAMBLE_BYTE;
                        if (q.pre_cnt != PRE_CNT_MAX) begin
                            d.pre_cnt = q.pre_cnt + 8'h01;
                        end
                    end
                end
            end
            T_SYNC: begin
                if (hs) begin
                    if (q.idx != sync_len) begin
                        d.tbyte = q.idx[0] ? sync_low_byte_i : sync_high_byte_i;
                        d.idx = q.idx + 3'h1;
                    end else if (!pull_if.valid) begin
                        d.tst = T_UNDER;
                        d.tvalid = 1'b0;
                    end else begin
                        pull_if.ready = ce_i;
                        d.tst = T_DATA;
                        d.tbyte = pull_if.data ^ twmask;
                        d.tpn = pn9_adv(q.tpn);
                        d.tcrc = crc_byte(CRC_INIT, pull_if.data);
                        d.len = pull_if.data; // only used in variable mode
                        d.cnt = (length_mode_select_i == LEN_VAR) ? 8'h00 : 8'h01;
                    end
                end
            end
            T_DATA: begin
                if (hs) begin
                    if (tx_last) begin
                        if (crc_enable_i) begin
                            d.tst = T_CRC;
                            d.tbyte = q.tcrc[15:8] ^ twmask; // checksum is whitened too
                            d.tpn = pn9_adv(q.tpn);
                            d.idx = 3'h0;
                        end else begin
                            d.tst = T_IDLE;
                            d.tvalid = 1'b0;
                            d.tdone = 1'b1;
                            d.nxt = tx_exit_state_i;
                        end
                    end else if (!pull_if.valid) begin
                        d.tst = T_UNDER; // left only by a stop from the host
                        d.tvalid = 1'b0;
                    end else begin
                        pull_if.ready = ce_i;
                        d.tbyte = pull_if.data ^ twmask;
                        d.tpn = pn9_adv(q.tpn);
                        d.tcrc = crc_byte(q.tcrc, pull_if.data);
                        d.cnt = q.cnt + 8'h01;
                    end
                end
            end
            T_CRC: begin
                if (hs) begin
                    if (q.idx == 3'h0) begin
                        d.tbyte = q.tcrc[7:0] ^ twmask;
                        d.tpn = pn9_adv(q.tpn);
                        d.idx = 3'h1;
                    end else begin
                        d.tst = T_IDLE;
                        d.tvalid = 1'b0;
                        d.tdone = 1'b1;
                        d.nxt = tx_exit_state_i;
                    end
                end
            end
            T_UNDER: begin
                if (tx_stop_i) begin
                    d.tst = T_IDLE;
                end
            end
            default: begin
                d.tst = T_IDLE;
                d.tvalid = 1'b0;
            end
        endcase
        // receive deframer; a held address byte goes out one cycle late
        if (q.rpend) begin
            d.rdata = q.raddr;
            d.rvalid = 1'b1;
            d.rpend = 1'b0;
        end
        case (q.rst)
            R_HUNT: begin
                if (rx_en_i && rx_sync_i) begin
                    d.rst = R_BODY;
                    d.rpn = PN9_INIT;
                    d.rcrc = CRC_INIT;
                    d.rcnt = 8'h00;
                    d.len_due = (length_mode_select_i == LEN_VAR);
                    d.adr_due = (address_check_mode_i != ADR_OFF);
                end
            end
            R_BODY: begin
                if (rx_byte_valid_i) begin
                    d.rpn = pn9_adv(q.rpn);
                    d.rcrc = crc_byte(q.rcrc, rx_in);
                    d.rdata = rx_in;
                    if (q.len_due) begin
                        d.len_due = 1'b0;
                        if (rx_in > packet_length_limit_i) begin
                            d.rst = R_HUNT; // dropped whatever the exit setting
                            d.rdiscard = 1'b1;
                        end else begin
                            d.rlen = rx_in;
                            d.rvalid = 1'b1;
                        end
                    end else begin
                        d.rcnt = rnext;
                        d.rvalid = 1'b1;
                        if (q.adr_due) begin
                            d.adr_due = 1'b0;
                            if (!adr_ok) begin
                                d.rst = R_HUNT;
                                d.rvalid = 1'b0;
                                d.rdiscard = 1'b1;
                            end else if (length_mode_select_i == LEN_INF) begin
                                d.rdata = INF_ADR_MARK;
                                d.raddr = rx_in;
                                d.rpend = 1'b1;
                            end
                        end
                        if (rx_end && !(q.adr_due && !adr_ok)) begin
                            d.rst = crc_enable_i ? R_CRC : (append_status_i ? R_STAT1 : R_HUNT);
                            d.ridx = 1'b0;
                            d.rdone = !crc_enable_i && !append_status_i;
                            if (!crc_enable_i && !append_status_i) begin
                                d.nxt = rx_exit_state_i;
                            end
                        end
                    end
                end
            end
            R_CRC: begin
                if (rx_byte_valid_i) begin
                    d.rpn = pn9_adv(q.rpn);
                    d.rcrc = crc_byte(q.rcrc, rx_in);
                    d.ridx = 1'b1;
                    if (q.ridx) begin
                        d.rst = append_status_i ? R_STAT1 : R_HUNT;
                        d.rdone = !append_status_i;
                        if (!append_status_i) begin
                            d.nxt = rx_exit_state_i;
                        end
                    end
                end
            end
            R_STAT1: begin
                d.rdata = signal_strength_value_i;
                d.rvalid = 1'b1;
                d.rst = R_STAT2;
            end
            R_STAT2: begin
                d.rdata = {crc_ok, link_quality_value_i};
                d.rvalid = 1'b1;
                d.rst = R_HUNT;
                d.rdone = 1'b1;
                d.nxt = rx_exit_state_i;
            end
            default: begin
                d.rst = R_HUNT;
            end
        endcase
        // dropping the receive enable ends an infinite packet too
        if (!rx_en_i && (q.rst != R_HUNT)) begin
            d.rst = R_HUNT;
            d.rdone = (length_mode_select_i == LEN_INF);
            d.nxt = rx_exit_state_i;
        end
    end

    // the whole state in one register; ce low freezes it
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign tx_sym_o = q.tbyte;
    assign tx_sym_valid_o = q.tvalid;
    assign tx_done_o = q.tdone;
    assign tx_underflow_o = (q.tst == T_UNDER);
    assign rx_data_o = q.rdata;
    assign rx_valid_o = q.rvalid;
    assign rx_done_o = q.rdone;
    assign rx_discard_o = q.rdiscard;
    assign exit_state_o = q.nxt;

    // checks sample only enabled edges so a frozen block never trips them
    default clocking cb @(posedge clk_i iff ce_i); endclocking
    default disable iff (!rstn_i);

    AST_PREAMBLE_BYTE: assert property ((q.tst == T_PRE) |-> (tx_sym_valid_o && tx_sym_o == PREAMBLE_BYTE))
        else $error("preamble byte is not 10101010");
    AST_SYNC_FOLLOWS_PRE: assert property (((q.tst == T_SYNC) && ($past(q.tst) == T_PRE))
        |-> (tx_sym_o == sync_high_byte_i))
        else $error("sync word did not follow preamble");
    AST_PRE_MINIMUM: assert property (((q.tst == T_PRE) && hs && (d.tst == T_SYNC))
        |-> (q.pre_cnt >= preamble_count_i && pull_if.valid))
        else $error("sync sent before preamble count or data");
    AST_SYNC_LENGTH: assert property (((q.tst == T_SYNC) && hs && (d.tst == T_DATA))
        |-> (q.idx == (sync32 ? 3'h4 : 3'h2)))
        else $error("wrong number of sync bytes");
    AST_PN9_SEED: assert property ((q.tst == T_SYNC) |-> (q.tpn == 9'h1ff))
        else $error("whitening not seeded with ones");
    AST_FIXED_END: assert property (((q.tst == T_DATA) && hs && !crc_enable_i &&
        (length_mode_select_i == LEN_FIXED) && (q.cnt == packet_length_limit_i))
        |=> (tx_done_o && !tx_sym_valid_o && exit_state_o == $past(tx_exit_state_i)))
        else $error("fixed packet did not end at limit");
    AST_LEN_DISCARD: assert property (((q.rst == R_BODY) && q.len_due && rx_byte_valid_i &&
        (rx_in > packet_length_limit_i)) |=> (rx_discard_o && !rx_valid_o && q.rst == R_HUNT))
        else $error("oversize length byte not discarded");
    AST_ADDR_REJECT: assert property (((q.rst == R_BODY) && !q.len_due && q.adr_due && rx_byte_valid_i &&
        !adr_ok && rx_en_i) |=> (rx_discard_o && q.rst == R_HUNT))
        else $error("address mismatch not discarded");
    AST_STATUS_BYTES: assert property (((q.rst == R_STAT1) && rx_en_i) |=>
        (rx_valid_o && rx_data_o == $past(signal_strength_value_i)) ##1 (rx_valid_o && rx_done_o))
        else $error("status bytes out of order");
    AST_STATUS_CRC: assert property (((q.rst == R_STAT2) && rx_en_i) |=>
        (rx_data_o == {$past(crc_ok), $past(link_quality_value_i)}))
        else $error("second status byte wrong");
    AST_INF_MARK: assert property (((q.rst == R_BODY) && rx_valid_o == 1'b0 && d.rpend)
        |=> (rx_data_o == INF_ADR_MARK) ##1 (rx_valid_o && rx_data_o == $past(q.raddr)))
        else $error("infinite address prefix wrong");

    COV_TX_FRAME: cover property ((q.tst == T_CRC) ##[1:300] tx_done_o);
    COV_TX_UNDER: cover property ((q.tst == T_DATA) ##1 tx_underflow_o);
    COV_RX_STATUS: cover property ((q.rst == R_STAT2) ##1 rx_done_o);
    COV_RX_DROP: cover property (rx_discard_o);
endmodule : radio_packet_handler
`default_nettype wire

// ==== testbench/modem_model.sv ====
// modem stand-in: takes transmit symbols, stalling every other cycle
// assumes one clock shared with the packet handler
`timescale 1ns/1ps
`default_nettype none
module modem_model (
    input wire logic clk_i,
    input wire logic [7:0] sym_i,
    input wire logic sym_valid_i,
    output logic sym_ready_o
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    // ready toggles regardless of valid, so both prompt and slow takes occur
    always @(negedge clk_i) begin
        slow <= ~slow;
        sym_ready_o <= slow;
    end
    // a byte counts only at an edge with valid and ready both high
    always @(posedge clk_i) begin
        if (sym_valid_i && sym_ready_o) got.push_back(sym_i);
    end
endmodule : modem_model
`default_nettype wire

// ==== testbench/radio_packet_handler_bench.sv ====
// bench: tx frames into the modem model, rx packets fed as byte strobes
// assumes 50 MHz clock, inputs changed on the falling edge
`timescale 1ns/1ps
`default_nettype none
module radio_packet_handler_bench;
    import pkt_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, tx_valid = 1'b0, tx_start = 1'b0, wh = 1'b0, rx_sync = 1'b0, rx_bv = 1'b0;
    logic [7:0] tx_data = 8'h00, sym, rx_byte = 8'h00, rx_data, pcnt = 8'h02, lim = 8'h02;
    logic [2:0] sq = 3'h2;
    logic [1:0] lm = 2'h0, exit_st;
    logic tx_ready, sym_valid, sym_ready, tx_done, rx_valid, rx_disc;
    logic ce = 1'b1, stop = 1'b0, rx_en = 1'b1, crc_en = 1'b0, app = 1'b1, tx_under, rx_done;
    logic [1:0] adr_m = 2'h1, tx_ex = 2'h1, rx_ex = 2'h3;
    logic [7:0] rxq[$];
    // the length byte of a packet dropped at its address has already gone to the host
    logic [7:0] exp_rx[9] = '{8'h02, 8'h02, 8'h42, 8'h55, 8'h9a, 8'h95, 8'hff, 8'h00, 8'h77};
    int error_cnt = 0, n_compared = 0, ndis = 0, ndone = 0;

    always #10 clk_i = ~clk_i;

    radio_packet_handler #(.DEPTH(16)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_start_i(tx_start),
        .tx_stop_i(stop), .tx_sym_o(sym), .tx_sym_valid_o(sym_valid), .tx_sym_ready_i(sym_ready),
        .tx_done_o(tx_done), .tx_underflow_o(tx_under), .rx_en_i(rx_en), .rx_sync_i(rx_sync), .rx_byte_i(rx_byte),
        .rx_byte_valid_i(rx_bv), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_done_o(rx_done),
        .rx_discard_o(rx_disc), .exit_state_o(exit_st), .preamble_count_i(pcnt), .sync_high_byte_i(8'h5b),
        .sync_low_byte_i(8'hc3), .sync_qualifier_mode_i(sq), .whitening_enable_i(wh), .crc_enable_i(crc_en),
        .append_status_i(app), .length_mode_select_i(lm), .packet_length_limit_i(lim),
        .address_check_mode_i(adr_m), .node_address_i(8'h42), .tx_exit_state_i(tx_ex),
        .rx_exit_state_i(rx_ex), .signal_strength_value_i(8'h9a), .link_quality_value_i(7'h15));

    modem_model mm (.clk_i(clk_i), .sym_i(sym), .sym_valid_i(sym_valid), .sym_ready_o(sym_ready));

    // receive side bookkeeping
    always @(posedge clk_i) begin
        if (rx_valid) rxq.push_back(rx_data);
        if (rx_disc) ndis++;
        if (rx_done) ndone++;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // start with an empty fifo, then load two bytes of a frame begun in mode m and ended in fixed-length mode
    task automatic tx_frame(input logic [2:0] q, input logic w, input logic [7:0] pc, input logic [1:0] m);
        int n;
        int s;
        lm = m; // configuration set while idle; lm changes again mid-frame below
        sq = q;
        wh = w;
        pcnt = pc;
        mm.got.delete();
        tx_start = 1'b1;
        @(negedge clk_i);
        tx_start = 1'b0;
        repeat (6) @(negedge clk_i);
        tx_data = 8'h11;
        tx_valid = 1'b1;
        @(negedge clk_i);
        tx_data = 8'h22;
        @(negedge clk_i);
        tx_valid = 1'b0;
        lm = LEN_FIXED; // under 256 bytes left: back to fixed mode
        for (n = 0; n < 200 && tx_done !== 1'b1; n++) @(negedge clk_i);
        chk("tx_done", {7'h0, tx_done}, 8'h01);
        chk("exit", {6'h0, exit_st}, 8'h01);
        repeat (3) @(negedge clk_i);
        s = (q == 3'h2) ? 2 : 4;
        n = mm.got.size() - s - 2;
        chk("pre_len", 8'(n >= int'(pc)), 8'h01);
        for (int i = 0; i < n; i++) chk("preamble", mm.got[i], PREAMBLE_BYTE);
        for (int i = 0; i < s; i++) chk("sync", mm.got[n+i], i[0] ? 8'hc3 : 8'h5b);
        // whitening masks ff then e1 from the all-ones seed
        chk("data0", mm.got[n+s], w ? 8'hee : 8'h11);
        chk("data1", mm.got[n+s+1], w ? 8'hc3 : 8'h22);
    endtask : tx_frame

    // sync pulse, then bytes three cycles apart, then room for status
    task automatic rx_pkt(input int n, input logic [23:0] b);
        @(negedge clk_i);
        rx_sync = 1'b1;
        @(negedge clk_i);
        rx_sync = 1'b0;
        for (int i = 0; i < n; i++) begin
            rx_byte = b[23-8*i -: 8];
            rx_bv = 1'b1;
            @(negedge clk_i);
            rx_bv = 1'b0;
            repeat (2) @(negedge clk_i);
        end
        repeat (8) @(negedge clk_i);
    endtask : rx_pkt

    initial begin
        repeat (4) @(negedge clk_i);
        rstn_i = 1'b1;
        tx_frame(3'h2, 1'b0, 8'h02, LEN_FIXED);
        tx_frame(3'h3, 1'b1, 8'h04, LEN_INF);
        tx_frame(3'h7, 1'b1, 8'h01, LEN_FIXED);
        // limit of three with only two bytes loaded runs the fifo dry mid frame
        lim = 8'h03;
        tx_valid = 1'b1;
        tx_start = 1'b1;
        @(negedge clk_i);
        tx_start = 1'b0;
        @(negedge clk_i);
        tx_valid = 1'b0;
        repeat (40) @(negedge clk_i);
        chk("underflow", {7'h0, tx_under}, 8'h01);
        // stop raised only while nothing is on air; a frozen block must ignore it
        ce = 1'b0;
        stop = 1'b1;
        repeat (2) @(negedge clk_i);
        chk("frozen", {7'h0, tx_under}, 8'h01);
        ce = 1'b1;
        @(negedge clk_i);
        stop = 1'b0;
        chk("stopped", {7'h0, tx_under}, 8'h00);
        wh = 1'b0; // receive bytes below are sent plain
        lm = LEN_VAR;
        lim = 8'h03;
        rx_pkt(1, 24'h050000);
        rx_pkt(3, 24'h024355);
        rx_pkt(3, 24'h024255);
        chk("rx_exit", {6'h0, exit_st}, 8'h03);
        // infinite packet to the zero broadcast address, ended by dropping the enable
        lm = LEN_INF;
        adr_m = ADR_BOTH;
        rx_pkt(2, 24'h007700);
        rx_en = 1'b0;
        @(negedge clk_i);
        rx_en = 1'b1;
        @(negedge clk_i);
        chk("discards", ndis[7:0], 8'h02);
        chk("rx_done", ndone[7:0], 8'h02);
        chk("rx_count", 8'(rxq.size()), 8'h09);
        for (int i = 0; i < 9; i++) chk("rx_byte", rxq[i], exp_rx[i]);
        stop_test();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
endmodule : radio_packet_handler_bench
`default_nettype wire
